// ---- sdpr_pkg.sv ----
// shared constants for the simple dual-port ram and its output path
package sdpr_pkg;
	localparam int SDPR_ADDR_W = 14;
	localparam int SDPR_ROW_BITS = 9;
	localparam int SDPR_ROWS = 512;
	localparam int SDPR_WORD_W = 40;
	localparam int SDPR_SLOT_BITS = 5;
	localparam int SDPR_DEF_WIDTH = 40;
	localparam logic [39:0] SDPR_DEF_INITVAL = 40'h00_0000_0000;
	localparam logic [39:0] SDPR_DEF_SRVAL = 40'h00_0000_0000;
	// ecc word layout: data, hamming check bits, overall parity
	localparam int SDPR_ECC_DATA_W = 32;
	localparam int SDPR_ECC_HAM_W = 6;
	localparam int SDPR_ECC_HAM_LSB = 32;
	localparam int SDPR_ECC_PAR_BIT = 38;
	// wishbone register map
	localparam logic [3:0] SDPR_CTRL_OFS = 4'h0;
	localparam logic [3:0] SDPR_STAT_OFS = 4'h4;
	localparam int SDPR_CTRL_INJ_LSB = 0;
	localparam int SDPR_CTRL_CLR_BIT = 2;
	localparam int SDPR_STAT_SB_LSB = 0;
	localparam int SDPR_STAT_DB_LSB = 16;
	localparam logic [1:0] SDPR_CTRL_RST = 2'h0;
	localparam logic [1:0] SDPR_INJ_ONE = 2'h1;
	localparam logic [1:0] SDPR_INJ_TWO = 2'h2;
	localparam logic [39:0] SDPR_INJ_MASK1 = 40'h00_0000_0001;
	localparam logic [39:0] SDPR_INJ_MASK2 = 40'h00_0000_0003;

	function automatic bit sdpr_width_ok(input int w);
		return w inside {1, 2, 4, 5, 8, 9, 10, 16, 18, 20, 32, 36, 40};
	endfunction

	// row width of the family a port width belongs to
	function automatic int sdpr_family(input int w);
		if (w inside {40, 20, 10, 5})
			return 40;
		if (w inside {36, 18, 9})
			return 36;
		return 32;
	endfunction

	function automatic int sdpr_slot_k(input int w);
		return $clog2(sdpr_family(w) / w);
	endfunction
endpackage

// ---- sdpr_ecc.sv ----
// secded encode and decode for 32 data bits in a 39-bit stored word
`timescale 1ns/1ns
`default_nettype none
module sdpr_ecc
	import sdpr_pkg::*;
(
	input wire logic [31:0] enc_data,
	output logic [6:0] enc_chk,
	input wire logic [38:0] dec_word,
	output logic [31:0] dec_data,
	output logic dec_sbit,
	output logic dec_dbit
);
	logic [5:0] ham_enc;
	logic [5:0] ham_dec;
	logic [5:0] syn;
	logic par_err;

	always_comb begin
		int d;
		d = 0;
		ham_enc = '0;
		ham_dec = '0;
		for (int pos = 1; pos <= 38; pos++) begin
			if ((pos & (pos - 1)) != 0) begin
				for (int i = 0; i < SDPR_ECC_HAM_W; i++) begin
					if (pos[i]) begin
						ham_enc[i] = ham_enc[i] ^ enc_data[d];
						ham_dec[i] = ham_dec[i] ^ dec_word[d];
					end
				end
				d++;
			end
		end
		enc_chk = {^{enc_data, ham_enc}, ham_enc};
	end

	assign syn = ham_dec ^ dec_word[SDPR_ECC_HAM_LSB +: SDPR_ECC_HAM_W];
	assign par_err = ^dec_word;

	// single error flips overall parity; a double leaves it even with a nonzero syndrome
	always_comb begin
		int k;
		k = 0;
		dec_data = dec_word[31:0];
		for (int pos = 1; pos <= 38; pos++) begin
			if ((pos & (pos - 1)) != 0) begin
				if (par_err && syn == 6'(pos))
					dec_data[k] = ~dec_word[k];
				k++;
			end
		end
	end

	assign dec_sbit = par_err;
	assign dec_dbit = !par_err && syn != 6'h00;
endmodule
`default_nettype wire

// ---- sdpr_wb_regs.sv ----
// wishbone slave: error injection control and ecc error counters
`timescale 1ns/1ns
`default_nettype none
module sdpr_wb_regs
	import sdpr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [1:0] inj_mode,
	input wire logic sbit_evt,
	input wire logic dbit_evt
);
	logic ack_ff;
	logic [31:0] dat_ff;
	logic [1:0] ctrl_ff;
	logic [15:0] sb_cnt_ff;
	logic [15:0] db_cnt_ff;
	logic req;
	logic clr;

	assign req = wb_cyc_i && wb_stb_i && !ack_ff;
	assign clr = req && wb_we_i && wb_sel_i[0] && wb_adr_i == SDPR_CTRL_OFS
		&& wb_dat_i[SDPR_CTRL_CLR_BIT];

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			ack_ff <= 1'b0;
		else
			ack_ff <= req;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			dat_ff <= '0;
		else if (req && !wb_we_i)
			unique case (wb_adr_i)
				SDPR_CTRL_OFS: dat_ff <= {30'h0000_0000, ctrl_ff};
				SDPR_STAT_OFS: dat_ff <= {db_cnt_ff, sb_cnt_ff};
				default: dat_ff <= '0;
			endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			ctrl_ff <= SDPR_CTRL_RST;
		else if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == SDPR_CTRL_OFS)
			ctrl_ff <= wb_dat_i[SDPR_CTRL_INJ_LSB +: 2];
	end

	// a counted event in the clearing cycle survives as a count of one
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sb_cnt_ff <= '0;
			db_cnt_ff <= '0;
		end else begin
			if (clr)
				sb_cnt_ff <= {15'h0000, sbit_evt};
			else if (sbit_evt && sb_cnt_ff != 16'hFFFF)
				sb_cnt_ff <= sb_cnt_ff + 16'h0001;
			if (clr)
				db_cnt_ff <= {15'h0000, dbit_evt};
			else if (dbit_evt && db_cnt_ff != 16'hFFFF)
				db_cnt_ff <= db_cnt_ff + 16'h0001;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;
	assign inj_mode = ctrl_ff;

	a_wb_ack_one: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single cycle after request");
endmodule
`default_nettype wire

// ---- sdpr_ram.sv ----
// simple dual-port ram with output latch, output register and ecc flags
// Summary of operation
// RQ1 - double error with decoder raises fault flag
// RQ2 - double error word is output uncorrected
// RQ3 - fault flags align with their data word
// RQ4 - read width from listed set, default 40
// RQ5 - write width same set, legal combinations
// RQ6 - each port clock edge rise or fall
// RQ7 - write enable polarity set by parameter
// RQ8 - read enable polarity set by parameter
// RQ9 - latch reset polarity set by parameter
// RQ10 - latency one cycle, two with register
// RQ11 - register reset polarity set by parameter
// RQ12 - reset priority or enable priority mode
// RQ13 - power-up value on latch and register
// RQ14 - reset value loaded by either reset
// RQ15 - clocked mode resets at next edge
// RQ16 - unclocked mode resets register at once
// RQ17 - access only on active edge when enabled
// RQ18 - latch reset loads value next edge
// RQ19 - register enable low holds outputs
// RQ20 - single error flagged and corrected
// RQ21 - illegal settings refused at elaboration
//
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module sdpr_ram
	import sdpr_pkg::*;
#(
	parameter int RD_W = SDPR_DEF_WIDTH, // RQ4
	parameter int WR_W = SDPR_DEF_WIDTH, // RQ5
	parameter bit WR_CLK_FALL = 1'b0,
	parameter bit RD_CLK_FALL = 1'b0,
	parameter bit WR_EN_HIGH = 1'b1,
	parameter bit RD_EN_HIGH = 1'b1,
	parameter bit LATCH_RST_HIGH = 1'b1,
	parameter bit OREG_RST_HIGH = 1'b1,
	parameter bit EN_OUT_REG = 1'b0,
	parameter bit OREG_PRIO_CE = 1'b0,
	parameter bit OUTREG_CLEAR_UNCLOCKED = 1'b0,
	parameter logic [39:0] READ_INITVAL = SDPR_DEF_INITVAL,
	parameter logic [39:0] READ_SRVAL = SDPR_DEF_SRVAL,
	parameter bit ENC_EN = 1'b0,
	parameter bit DEC_EN = 1'b0
)(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic wr_en,
	input wire logic [13:0] wr_addr,
	input wire logic [39:0] wr_data,
	input wire logic rd_en,
	input wire logic [13:0] rd_addr,
	input wire logic latch_rst,
	input wire logic oreg_rst,
	input wire logic oreg_ce,
	output logic [39:0] rd_data,
	output logic sbit_err,
	output logic dbit_err,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	localparam int RD_K = sdpr_slot_k(RD_W);
	localparam int WR_K = sdpr_slot_k(WR_W);
	localparam logic [39:0] RD_MASK = 40'((41'h1 << RD_W) - 41'h1);
	localparam logic [39:0] INIT_M = READ_INITVAL & RD_MASK;
	localparam logic [39:0] SRVAL_M = READ_SRVAL & RD_MASK;

	// RQ21
	if (!sdpr_width_ok(RD_W) || !sdpr_width_ok(WR_W)
		|| sdpr_family(RD_W) != sdpr_family(WR_W)) begin : g_bad_width
		$error("unsupported read/write width combination");
	end
	if ((ENC_EN || DEC_EN) && (RD_W != SDPR_WORD_W || WR_W != SDPR_WORD_W)) begin : g_bad_ecc
		$error("ecc needs both ports at full width");
	end

	logic wclk;
	logic rclk;
	logic wr_act;
	logic rd_act;
	logic lrst_act;
	logic orst_act;
	logic oreg_arst;
	logic [39:0] mem_q [SDPR_ROWS];
	logic [SDPR_ROW_BITS-1:0] wr_row;
	logic [SDPR_ROW_BITS-1:0] rd_row;
	logic [4:0] wr_slot;
	logic [4:0] rd_slot;
	logic [5:0] wr_off;
	logic [5:0] rd_off;
	logic [39:0] raw_row;
	logic [39:0] dec_row;
	logic [39:0] rd_word;
	logic [6:0] enc_chk;
	logic [31:0] dec_data;
	logic dec_sbit;
	logic dec_dbit;
	logic [1:0] inj_mode;
	logic [39:0] inj_mask;
	logic [39:0] wr_word;
	logic [39:0] lat_data_ff;
	logic lat_sbit_ff;
	logic lat_dbit_ff;
	logic [39:0] oreg_data_ff;
	logic oreg_sbit_ff;
	logic oreg_dbit_ff;
	logic sbit_evt_ff;
	logic dbit_evt_ff;

	// the falling-edge option inverts the port clock rather than adding a domain
	assign wclk = WR_CLK_FALL ? ~ref_clk : ref_clk; // RQ6
	assign rclk = RD_CLK_FALL ? ~ref_clk : ref_clk; // RQ6

	assign wr_act = wr_en == WR_EN_HIGH; // RQ7
	assign rd_act = rd_en == RD_EN_HIGH; // RQ8
	assign lrst_act = latch_rst == LATCH_RST_HIGH; // RQ9
	assign orst_act = oreg_rst == OREG_RST_HIGH; // RQ11
	assign oreg_arst = OUTREG_CLEAR_UNCLOCKED && EN_OUT_REG && orst_act; // RQ16

	// address is top-justified: row in the high bits, slot just below
	assign wr_row = wr_addr[13 -: SDPR_ROW_BITS];
	assign rd_row = rd_addr[13 -: SDPR_ROW_BITS];
	assign wr_slot = 5'(wr_addr[4:0] >> (SDPR_SLOT_BITS - WR_K));
	assign rd_slot = 5'(rd_addr[4:0] >> (SDPR_SLOT_BITS - RD_K));
	assign wr_off = 6'(int'(wr_slot) * WR_W);
	assign rd_off = 6'(int'(rd_slot) * RD_W);

	sdpr_ecc u_ecc (
		.enc_data(wr_data[31:0]),
		.enc_chk(enc_chk),
		.dec_word(raw_row[38:0]),
		.dec_data(dec_data),
		.dec_sbit(dec_sbit),
		.dec_dbit(dec_dbit)
	);

	sdpr_wb_regs u_regs (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.inj_mode(inj_mode),
		.sbit_evt(sbit_evt_ff),
		.dbit_evt(dbit_evt_ff)
	);

	// injection flips stored bits so software can exercise the decoder
	always_comb begin
		unique case (inj_mode)
			SDPR_INJ_ONE: inj_mask = SDPR_INJ_MASK1;
			SDPR_INJ_TWO: inj_mask = SDPR_INJ_MASK2;
			default: inj_mask = '0;
		endcase
	end

	assign wr_word = ENC_EN ? {wr_data[39], enc_chk, wr_data[31:0]} : wr_data;

	// no reset on the array: contents are undefined until written
	always_ff @(posedge wclk) begin
		if (wr_act) begin // RQ17
			if (WR_W == SDPR_WORD_W)
				mem_q[wr_row] <= wr_word ^ inj_mask;
			else
				mem_q[wr_row][wr_off +: WR_W] <= wr_data[WR_W-1:0] ^ inj_mask[WR_W-1:0];
		end
	end

	assign raw_row = mem_q[rd_row];
	// corrected on single error, raw on double error
	assign dec_row = {raw_row[39:32], (dec_sbit ? dec_data : raw_row[31:0])}; // RQ2 RQ20
	assign rd_word = (DEC_EN ? dec_row : 40'(raw_row >> rd_off)) & RD_MASK;

	// output latch: loads on an enabled read, reset value wins
	always_ff @(posedge rclk or negedge rst_b) begin
		if (!rst_b) begin
			lat_data_ff <= INIT_M; // RQ13
			lat_sbit_ff <= 1'b0;
			lat_dbit_ff <= 1'b0;
		end else if (lrst_act) begin
			lat_data_ff <= SRVAL_M; // RQ18 RQ14
			lat_sbit_ff <= 1'b0;
			lat_dbit_ff <= 1'b0;
		end else if (rd_act) begin
			lat_data_ff <= rd_word; // RQ17 RQ10
			lat_sbit_ff <= DEC_EN && dec_sbit; // RQ20 RQ3
			lat_dbit_ff <= DEC_EN && dec_dbit; // RQ1 RQ3
		end
	end

	// output register: second stage when enabled
	always_ff @(posedge rclk or negedge rst_b or posedge oreg_arst) begin
		if (!rst_b) begin
			oreg_data_ff <= INIT_M; // RQ13
			oreg_sbit_ff <= 1'b0;
			oreg_dbit_ff <= 1'b0;
		end else if (oreg_arst) begin
			oreg_data_ff <= SRVAL_M; // RQ16 RQ14
			oreg_sbit_ff <= 1'b0;
			oreg_dbit_ff <= 1'b0;
		end else if (orst_act && (!OREG_PRIO_CE || oreg_ce)) begin
			oreg_data_ff <= SRVAL_M; // RQ12 RQ15
			oreg_sbit_ff <= 1'b0;
			oreg_dbit_ff <= 1'b0;
		end else if (oreg_ce) begin
			oreg_data_ff <= lat_data_ff; // RQ19 RQ10
			oreg_sbit_ff <= lat_sbit_ff; // RQ3
			oreg_dbit_ff <= lat_dbit_ff; // RQ3
		end
	end

	// counter events take the decoder flags of an enabled read once per rising ref_clk edge
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sbit_evt_ff <= 1'b0;
			dbit_evt_ff <= 1'b0;
		end else begin
			sbit_evt_ff <= rd_act && !lrst_act && DEC_EN && dec_sbit;
			dbit_evt_ff <= rd_act && !lrst_act && DEC_EN && dec_dbit;
		end
	end

	// with the register off the latch drives the pins and oreg_ce is ignored
	if (EN_OUT_REG) begin : g_oreg
		assign rd_data = oreg_data_ff; // RQ10
		assign sbit_err = oreg_sbit_ff;
		assign dbit_err = oreg_dbit_ff;
	end else begin : g_latch
		assign rd_data = lat_data_ff; // RQ10 RQ19
		assign sbit_err = lat_sbit_ff;
		assign dbit_err = lat_dbit_ff;
	end

	sequence s_read;
		rd_act && !lrst_act;
	endsequence

	sequence s_load;
		oreg_ce && !orst_act && !oreg_arst;
	endsequence

	a_latch_one_cycle: assert property (@(posedge rclk) disable iff (!rst_b) // RQ10
		s_read |=> lat_data_ff == $past(rd_word))
		else $error("latch did not take read word after one cycle");

	a_latch_reset_val: assert property (@(posedge rclk) disable iff (!rst_b) // RQ18
		lrst_act |=> lat_data_ff == SRVAL_M && !lat_dbit_ff && !lat_sbit_ff)
		else $error("latch reset value not loaded");

	a_dbit_flag_set: assert property (@(posedge rclk) disable iff (!rst_b) // RQ1
		(s_read and (DEC_EN && dec_dbit)) |=> lat_dbit_ff && !lat_sbit_ff)
		else $error("double error not flagged");

	a_dbit_word_raw: assert property (@(posedge rclk) disable iff (!rst_b) // RQ2
		(s_read and (DEC_EN && dec_dbit)) |=> lat_data_ff == $past(raw_row & RD_MASK))
		else $error("double error word was altered");

	a_sbit_flag_set: assert property (@(posedge rclk) disable iff (!rst_b) // RQ20
		(s_read and (DEC_EN && dec_sbit)) |=> lat_sbit_ff)
		else $error("single error not flagged");

	a_oreg_two_cycle: assert property (@(posedge rclk) disable iff (!rst_b) // RQ10
		(EN_OUT_REG && rd_act && !lrst_act) ##1 s_load
		|=> rd_data == $past(rd_word, 2) && dbit_err == $past(DEC_EN && dec_dbit, 2))
		else $error("registered read data or flag misaligned");

	a_oreg_hold_ce: assert property (@(posedge rclk) disable iff (!rst_b) // RQ19
		(EN_OUT_REG && !oreg_ce && !orst_act && !oreg_arst) |=> $stable(rd_data))
		else $error("output moved while register enable low");

	a_oreg_rst_prio: assert property (@(posedge rclk) disable iff (!rst_b) // RQ12
		(EN_OUT_REG && !OUTREG_CLEAR_UNCLOCKED && orst_act && (!OREG_PRIO_CE || oreg_ce))
		|=> rd_data == SRVAL_M)
		else $error("output register reset not applied");

	a_oreg_async_rst: assert property (@(posedge rclk) disable iff (!rst_b) // RQ16
		oreg_arst |-> oreg_data_ff == SRVAL_M && !oreg_dbit_ff)
		else $error("unclocked reset not holding reset value");

	a_rd_idle_hold: assert property (@(posedge rclk) disable iff (!rst_b) // RQ17
		(!rd_act && !lrst_act) |=> $stable(lat_data_ff))
		else $error("latch changed without an enabled read");

	// flags must travel through the register with their own word
	a_oreg_flag_align: assert property (@(posedge rclk) disable iff (!rst_b) // RQ3
		(EN_OUT_REG && s_load) |=> oreg_sbit_ff == $past(lat_sbit_ff)
		&& oreg_dbit_ff == $past(lat_dbit_ff))
		else $error("register flags not aligned with data");

	// enable-priority mode: a clocked reset without the enable must not touch the register
	a_ce_prio_hold: assert property (@(posedge rclk) disable iff (!rst_b) // RQ12
		(EN_OUT_REG && OREG_PRIO_CE && !oreg_ce && !oreg_arst) |=> $stable(oreg_data_ff))
		else $error("register moved in enable-priority mode without enable");

	a_rd_upper_zero: assert property (@(posedge rclk) disable iff (!rst_b) // RQ4
		(rd_data & ~RD_MASK) == 40'h00_0000_0000)
		else $error("read data has bits above the read width");

	a_flags_exclusive: assert property (@(posedge rclk) disable iff (!rst_b) // RQ1
		!(lat_sbit_ff && lat_dbit_ff))
		else $error("single and double flags raised together");

	// full-width writes only; narrow writes land in a slice of the row
	a_wr_stored: assert property (@(posedge wclk) // RQ17
		(wr_act && WR_W == SDPR_WORD_W) |=> mem_q[$past(wr_row)] == $past(wr_word ^ inj_mask))
		else $error("write word not stored");
endmodule
`default_nettype wire

// ---- sdpr_fabric_model.sv ----
// fabric-side model driving the ram write and read ports
`timescale 1ns/1ns
`default_nettype none
module sdpr_fabric_model (
	input wire logic ref_clk,
	output logic wr_en,
	output logic [13:0] wr_addr,
	output logic [39:0] wr_data,
	output logic rd_en,
	output logic [13:0] rd_addr
);
	initial begin
		wr_en = 1'b0;
		wr_addr = 14'h0000;
		wr_data = 40'h00_0000_0000;
		rd_en = 1'b0;
		rd_addr = 14'h0000;
	end

	// go tasks leave the enable up so accesses can run back to back
	task automatic wr_go(input logic [13:0] a, input logic [39:0] d);
		@(posedge ref_clk);
		wr_en <= 1'b1;
		wr_addr <= a;
		wr_data <= d;
	endtask

	// released lines show the inverse so a stale word never looks valid
	task automatic wr_stop();
		@(posedge ref_clk);
		wr_en <= 1'b0;
		wr_addr <= ~wr_addr;
		wr_data <= ~wr_data;
	endtask

	task automatic rd_go(input logic [13:0] a);
		@(posedge ref_clk);
		rd_en <= 1'b1;
		rd_addr <= a;
	endtask

	task automatic rd_stop();
		@(posedge ref_clk);
		rd_en <= 1'b0;
		rd_addr <= ~rd_addr;
	endtask
endmodule
`default_nettype wire

// ---- sdpr_ram_tb.sv ----
// self-checking bench for the ram output path, ecc flags and registers
`timescale 1ns/1ns
`default_nettype none
module sdpr_ram_tb import sdpr_pkg::*; ;
	localparam logic [39:0] INIT_A = 40'h12_3456_789A;
	localparam logic [39:0] SR_A = 40'h55_AAAA_5555;
	logic ref_clk, rst_b, wr_en, rd_en, latch_rst, oreg_rst, oreg_ce;
	logic [13:0] wr_addr, rd_addr;
	logic [39:0] wr_data, rd_data, b_data;
	logic sbit_err, dbit_err, b_sbit, b_dbit, b_ack, wb_ack_o;
	logic wb_cyc_i, wb_stb_i, wb_we_i;
	logic [3:0] wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, b_wdat, rv;
	logic [39:0] c_data;
	int miscompares = 0;
	int num_checks = 0;

	sdpr_fabric_model u_fab (.*);
	// ecc and output register on, nonzero power-up and reset values
	sdpr_ram #(.EN_OUT_REG(1'b1), .ENC_EN(1'b1), .DEC_EN(1'b1), .READ_INITVAL(INIT_A),
		.READ_SRVAL(SR_A)) u_dut (.*);
	// default configuration shares every input, so raw stored words are visible
	sdpr_ram u_dut_b (.*, .rd_data(b_data), .sbit_err(b_sbit), .dbit_err(b_dbit),
		.wb_dat_o(b_wdat), .wb_ack_o(b_ack));
	// active-low controls driven inverted, enable-priority register reset
	sdpr_ram #(.WR_EN_HIGH(1'b0), .RD_EN_HIGH(1'b0), .LATCH_RST_HIGH(1'b0),
		.OREG_RST_HIGH(1'b0), .EN_OUT_REG(1'b1), .OREG_PRIO_CE(1'b1)) u_dut_c (.*,
		.wr_en(!wr_en), .rd_en(!rd_en), .latch_rst(!latch_rst), .oreg_rst(!oreg_rst),
		.rd_data(c_data), .sbit_err(), .dbit_err(), .wb_dat_o(), .wb_ack_o());

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	function automatic logic [13:0] adr(input int r);
		return 14'(r << 5);
	endfunction

	function automatic logic [39:0] pat(input int r);
		return {8'(r), 32'hC0DE_0000 | 32'(r)};
	endfunction

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk_data(input string what, input logic [39:0] exp, input logic [39:0] got);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_flag(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %s expected %b seen %b", what, exp, got);
		end
	endtask

	// classic single cycle; ack sampled at the edge, release right after it
	task automatic wb_io(input logic we, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rv = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			miscompares++;
			give_verdict();
		end
	endtask

	initial begin
		rst_b = 1'b0;
		latch_rst = 1'b0;
		oreg_rst = 1'b0;
		oreg_ce = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 4'h0;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0000_0000;
		repeat (12) @(posedge ref_clk);
		rst_b <= 1'b1;
		#1;
		chk_data("init a", INIT_A, rd_data);
		chk_data("init b", SDPR_DEF_INITVAL, b_data);
		for (int r = 1; r <= 3; r++) begin
			u_fab.wr_go(adr(r), pat(r));
		end
		u_fab.wr_stop();
		u_fab.rd_go(adr(1));
		u_fab.rd_go(adr(2));
		#1;
		chk_data("b lat1", pat(1), b_data);
		u_fab.rd_stop();
		#1;
		chk_data("b next", pat(2), b_data);
		chk_word("a lat2", 32'(pat(1)), rd_data[31:0]);
		chk_data("c lat2", pat(1), c_data);
		chk_flag("a sbit clean", 1'b0, sbit_err);
		@(posedge ref_clk);
		#1;
		chk_word("a next", 32'(pat(2)), rd_data[31:0]);
		chk_data("b idle", pat(2), b_data);
		@(posedge ref_clk);
		oreg_ce <= 1'b0;
		u_fab.rd_go(adr(3));
		u_fab.rd_stop();
		repeat (2) @(posedge ref_clk);
		#1;
		chk_word("a held", 32'(pat(2)), rd_data[31:0]);
		chk_data("b no reg", pat(3), b_data);
		@(posedge ref_clk);
		oreg_ce <= 1'b1;
		@(posedge ref_clk);
		#1;
		chk_word("a load", 32'(pat(3)), rd_data[31:0]);
		@(posedge ref_clk);
		latch_rst <= 1'b1;
		u_fab.rd_go(adr(1));
		u_fab.rd_stop();
		latch_rst <= 1'b0;
		#1;
		chk_data("b latch rst", SDPR_DEF_SRVAL, b_data);
		@(posedge ref_clk);
		#1;
		chk_data("a latch rst", SR_A, rd_data);
		chk_data("c latch rst", SDPR_DEF_SRVAL, c_data);
		u_fab.rd_go(adr(2));
		u_fab.rd_stop();
		@(posedge ref_clk);
		oreg_ce <= 1'b0;
		oreg_rst <= 1'b1;
		#1;
		chk_word("a before clr", 32'(pat(2)), rd_data[31:0]);
		@(posedge ref_clk);
		oreg_rst <= 1'b0;
		oreg_ce <= 1'b1;
		#1;
		chk_data("a reg rst", SR_A, rd_data);
		chk_data("c prio hold", pat(2), c_data);
		wb_io(1'b1, SDPR_CTRL_OFS, 32'(SDPR_INJ_ONE));
		wb_io(1'b0, SDPR_CTRL_OFS, 32'h0000_0000);
		chk_word("ctrl", 32'(SDPR_INJ_ONE), rv);
		u_fab.wr_go(adr(5), pat(5));
		u_fab.wr_stop();
		wb_io(1'b1, SDPR_CTRL_OFS, 32'(SDPR_INJ_TWO));
		u_fab.wr_go(adr(6), pat(6));
		u_fab.wr_stop();
		wb_io(1'b1, SDPR_CTRL_OFS, 32'h0000_0000);
		u_fab.rd_go(adr(5));
		u_fab.rd_go(adr(6));
		#1;
		chk_data("b raw one", pat(5) ^ SDPR_INJ_MASK1, b_data);
		chk_flag("a sbit early", 1'b0, sbit_err);
		u_fab.rd_stop();
		#1;
		chk_data("b raw two", pat(6) ^ SDPR_INJ_MASK2, b_data);
		chk_flag("b sbit off", 1'b0, b_sbit);
		chk_flag("b dbit off", 1'b0, b_dbit);
		chk_word("a fixed", 32'(pat(5)), rd_data[31:0]);
		chk_flag("a sbit", 1'b1, sbit_err);
		chk_flag("a dbit quiet", 1'b0, dbit_err);
		@(posedge ref_clk);
		#1;
		chk_word("a uncorrected", 32'(pat(6) ^ SDPR_INJ_MASK2), rd_data[31:0]);
		chk_flag("a dbit", 1'b1, dbit_err);
		chk_flag("a sbit quiet", 1'b0, sbit_err);
		wb_io(1'b0, SDPR_STAT_OFS, 32'h0000_0000);
		chk_word("stat", 32'h0001_0001, rv);
		wb_io(1'b1, SDPR_CTRL_OFS, 32'(1 << SDPR_CTRL_CLR_BIT));
		wb_io(1'b0, SDPR_STAT_OFS, 32'h0000_0000);
		chk_word("stat clr", 32'h0000_0000, rv);
		wb_io(1'b0, 4'h8, 32'h0000_0000);
		chk_word("unmapped", 32'h0000_0000, rv);
		give_verdict();
	end
endmodule
`default_nettype wire
